// ===== logic/hrfd_params.svh
`ifndef HRFD_PARAMS_SVH
`define HRFD_PARAMS_SVH
`define HRFD_START 8'h7e
`define HRFD_CSUM_OK 8'hff
`define HRFD_T_LEGACY 8'h00
`define HRFD_T_ATNOW 8'h08
`define HRFD_T_ATQ 8'h09
`define HRFD_T_TX 8'h10
`define HRFD_T_ATRSP 8'h88
`define HRFD_BCAST 64'h0000_0000_0000_ffff
`define HRFD_MIN_LEGACY 16'h000b
`define HRFD_MIN_AT 16'h0004
`define HRFD_MIN_TX 16'h000e
`define HRFD_OFF_TYPE 16'h0003
`define HRFD_OFF_FID 16'h0004
`define HRFD_OFF_DST 16'h0005
`define HRFD_OFF_DST_END 16'h000c
`define HRFD_OFF_LOPT 16'h000d
`define HRFD_OFF_LPAY 16'h000e
`define HRFD_OFF_CODE 16'h0005
`define HRFD_OFF_CODE_LO 16'h0006
`define HRFD_OFF_HOPS 16'h000f
`define HRFD_OFF_TXOPT 16'h0010
`define HRFD_OFF_TPAY 16'h0011
`define HRFD_IDX_TO_OFF 16'h0003
`define HRFD_VAL_MAX 3'd4
`define HRFD_CODE_RATE 16'h4244
`define HRFD_CODE_HOPS 16'h4e48
`define HRFD_CODE_APPLY 16'h4143
`define HRFD_A_CTRL 8'h00
`define HRFD_A_STAT 8'h04
`define HRFD_A_GOOD 8'h08
`define HRFD_A_BAD 8'h0c
`define HRFD_A_RATE 8'h10
`define HRFD_A_HOPS 8'h14
`define HRFD_RST_RATE 32'h0000_0003
`define HRFD_RST_HOPS 8'h07
`define HRFD_RST_EN 1'b1
`endif

// ===== logic/hrfd_pkg.sv
package hrfd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LENH = 2'b01,
        ST_LENL = 2'b10,
        ST_BODY = 2'b11
    } hrfd_state_t;

    typedef struct packed {
        logic [7:0] ftype;
        logic [7:0] fid;
        logic [63:0] dest;
        logic [7:0] opts;
        logic [7:0] hops;
        logic resp_due;
        logic bcast;
    } hrfd_frame_t;

    typedef struct packed {
        hrfd_state_t st;
        logic [15:0] len;
        logic [15:0] idx;
        logic [7:0] sum;
        hrfd_frame_t cur;
        hrfd_frame_t out;
        logic [15:0] code;
        logic [31:0] val;
        logic [2:0] nval;
        logic frm_valid;
        logic frm_err;
        logic pay_valid;
        logic [7:0] pay_data;
        logic [15:0] stg_code;
        logic [31:0] stg_val;
        logic stg_pend;
        logic [31:0] rate;
        logic [7:0] hop_lim;
        logic en;
        logic [15:0] good;
        logic [15:0] bad;
        logic par_set;
        logic par_query;
        logic [15:0] par_code;
        logic [31:0] par_val;
        logic [31:0] prdata;
    } hrfd_regs_t;
endpackage

// ===== logic/hrfd_decoder.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "hrfd_params.svh"

module hrfd_decoder (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    output logic FRM_VALID,
    output logic FRM_ERR,
    output hrfd_pkg::hrfd_frame_t FRM,
    output logic PAY_VALID,
    output logic [7:0] PAY_DATA,
    output logic PAR_SET,
    output logic PAR_QUERY,
    output logic [15:0] PAR_CODE,
    output logic [31:0] PAR_VAL,
    output logic [31:0] SERIAL_RATE,
    output logic [7:0] HOP_LIMIT
);
    import hrfd_pkg::*;

    hrfd_regs_t r_r;
    hrfd_regs_t r_nxt;
    logic [15:0] off;
    logic [7:0] sum_nxt;
    logic hit;
    logic is_at;
    logic is_tx;
    logic len_ok;
    logic opt_ok;

    // Only the active copies drive the rest of the device; staged values never leak out
    function automatic hrfd_regs_t apply(input hrfd_regs_t s, input logic [15:0] c, input logic [31:0] v);
        hrfd_regs_t t;
        t = s;
        if (c == `HRFD_CODE_RATE) begin
            t.rate = v;
        end else if (c == `HRFD_CODE_HOPS) begin
            t.hop_lim = v[7:0];
        end
        t.par_set = 1'b1;
        t.par_code = c;
        t.par_val = v;
        return t;
    endfunction

    assign off = r_r.idx + `HRFD_IDX_TO_OFF;
    assign sum_nxt = r_r.sum + RX_DATA;
    assign is_at = (r_r.cur.ftype == `HRFD_T_ATNOW) || (r_r.cur.ftype == `HRFD_T_ATQ);
    assign is_tx = (r_r.cur.ftype == `HRFD_T_TX);
    assign hit = (PADDR == `HRFD_A_CTRL) || (PADDR == `HRFD_A_STAT) || (PADDR == `HRFD_A_GOOD)
        || (PADDR == `HRFD_A_BAD) || (PADDR == `HRFD_A_RATE) || (PADDR == `HRFD_A_HOPS);

    always_comb begin
        if (r_r.cur.ftype == `HRFD_T_LEGACY) begin
            len_ok = r_r.len >= `HRFD_MIN_LEGACY;
        end else if (is_tx) begin
            len_ok = r_r.len >= `HRFD_MIN_TX;
        end else begin
            len_ok = (r_r.len >= `HRFD_MIN_AT) && (r_r.nval <= `HRFD_VAL_MAX);
        end
        if (is_tx) begin
            opt_ok = (r_r.cur.opts[5:4] == 2'b00) && (r_r.cur.opts[7:6] != 2'b00);
        end else if (r_r.cur.ftype == `HRFD_T_LEGACY) begin
            opt_ok = r_r.cur.opts[7:1] == 7'h00;
        end else begin
            opt_ok = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_nxt = r_r;
        r_nxt.frm_valid = 1'b0;
        r_nxt.frm_err = 1'b0;
        r_nxt.pay_valid = 1'b0;
        r_nxt.par_set = 1'b0;
        r_nxt.par_query = 1'b0;
        // Read data is latched in the setup phase so it stands for the whole access
        if (PSEL && !PENABLE) begin
            if (PADDR == `HRFD_A_CTRL) begin
                r_nxt.prdata = {31'h0000_0000, r_r.en};
            end else if (PADDR == `HRFD_A_STAT) begin
                r_nxt.prdata = {16'h0000, r_r.out.ftype, 7'h00, r_r.stg_pend};
            end else if (PADDR == `HRFD_A_GOOD) begin
                r_nxt.prdata = {16'h0000, r_r.good};
            end else if (PADDR == `HRFD_A_BAD) begin
                r_nxt.prdata = {16'h0000, r_r.bad};
            end else if (PADDR == `HRFD_A_RATE) begin
                r_nxt.prdata = r_r.rate;
            end else if (PADDR == `HRFD_A_HOPS) begin
                r_nxt.prdata = {24'h00_0000, r_r.hop_lim};
            end else begin
                r_nxt.prdata = 32'h0000_0000;
            end
        end
        // Software writes go first so a frame applied in the same cycle wins
        if (PSEL && PENABLE && PWRITE) begin
            if (PADDR == `HRFD_A_CTRL) begin
                r_nxt.en = PWDATA[0];
            end else if (PADDR == `HRFD_A_RATE) begin
                r_nxt.rate = PWDATA;
            end else if (PADDR == `HRFD_A_HOPS) begin
                r_nxt.hop_lim = PWDATA[7:0];
            end
        end
        if (!r_r.en) begin
            r_nxt.st = ST_IDLE;
        end else if (RX_VALID) begin
            case (r_r.st)
                ST_IDLE: begin
                    // Bytes before a start byte are dropped
                    if (RX_DATA == `HRFD_START) begin
                        r_nxt.st = ST_LENH;
                    end
                end
                ST_LENH: begin
                    r_nxt.len[15:8] = RX_DATA;
                    r_nxt.st = ST_LENL;
                end
                ST_LENL: begin
                    r_nxt.len[7:0] = RX_DATA;
                    r_nxt.idx = 16'h0000;
                    r_nxt.sum = 8'h00;
                    r_nxt.cur = '0;
                    r_nxt.code = 16'h0000;
                    r_nxt.val = 32'h0000_0000;
                    r_nxt.nval = 3'd0;
                    r_nxt.st = ST_BODY;
                end
                ST_BODY: begin
                    r_nxt.sum = sum_nxt;
                    r_nxt.idx = r_r.idx + 16'h0001;
                    if (r_r.idx == r_r.len) begin
                        // This byte is the checksum
                        r_nxt.st = ST_IDLE;
                        if (sum_nxt == `HRFD_CSUM_OK && len_ok && opt_ok
                            && (is_at || is_tx || r_r.cur.ftype == `HRFD_T_LEGACY)) begin
                            r_nxt.frm_valid = 1'b1;
                            r_nxt.good = r_r.good + 16'h0001;
                            r_nxt.out = r_r.cur;
                            r_nxt.out.resp_due = r_r.cur.fid != 8'h00;
                            r_nxt.out.bcast = (!is_at) && (r_r.cur.dest == `HRFD_BCAST);
                            if (is_tx && r_r.cur.hops == 8'h00) begin
                                r_nxt.out.hops = r_r.hop_lim;
                            end
                            if (is_at) begin
                                r_nxt.out.dest = 64'h0;
                                r_nxt.out.opts = 8'h00;
                            end
                            if (r_r.cur.ftype == `HRFD_T_ATNOW) begin
                                // Pending value first, so this frame's own value lands last
                                if (r_r.stg_pend) begin
                                    r_nxt = apply(r_nxt, r_r.stg_code, r_r.stg_val);
                                    r_nxt.stg_pend = 1'b0;
                                end
                                if (r_r.nval != 3'd0) begin
                                    r_nxt = apply(r_nxt, r_r.code, r_r.val);
                                end else if (r_r.code != `HRFD_CODE_APPLY) begin
                                    r_nxt.par_query = 1'b1;
                                    r_nxt.par_code = r_r.code;
                                end
                            end else if (r_r.cur.ftype == `HRFD_T_ATQ) begin
                                if (r_r.code == `HRFD_CODE_APPLY) begin
                                    if (r_r.stg_pend) begin
                                        r_nxt = apply(r_nxt, r_r.stg_code, r_r.stg_val);
                                    end
                                    r_nxt.stg_pend = 1'b0;
                                end else if (r_r.nval != 3'd0) begin
                                    // One staging slot only: a second queued value replaces the first
                                    r_nxt.stg_code = r_r.code;
                                    r_nxt.stg_val = r_r.val;
                                    r_nxt.stg_pend = 1'b1;
                                end else begin
                                    r_nxt.par_query = 1'b1;
                                    r_nxt.par_code = r_r.code;
                                end
                            end
                        end else begin
                            r_nxt.frm_err = 1'b1;
                            r_nxt.bad = r_r.bad + 16'h0001;
                        end
                    end else if (off == `HRFD_OFF_TYPE) begin
                        r_nxt.cur.ftype = RX_DATA;
                    end else if (off == `HRFD_OFF_FID) begin
                        r_nxt.cur.fid = RX_DATA;
                    end else if (is_at) begin
                        if (off == `HRFD_OFF_CODE || off == `HRFD_OFF_CODE_LO) begin
                            r_nxt.code = {r_r.code[7:0], RX_DATA};
                        end else begin
                            // Shifting in keeps zero-padded forms equal
                            r_nxt.val = {r_r.val[23:0], RX_DATA};
                            if (r_r.nval != 3'd7) begin
                                r_nxt.nval = r_r.nval + 3'd1;
                            end
                        end
                    end else if (off >= `HRFD_OFF_DST && off <= `HRFD_OFF_DST_END) begin
                        r_nxt.cur.dest = {r_r.cur.dest[55:0], RX_DATA};
                    end else if (r_r.cur.ftype == `HRFD_T_LEGACY) begin
                        if (off == `HRFD_OFF_LOPT) begin
                            r_nxt.cur.opts = RX_DATA;
                        end else begin
                            r_nxt.pay_valid = 1'b1;
                            r_nxt.pay_data = RX_DATA;
                        end
                    end else if (is_tx) begin
                        if (off == `HRFD_OFF_HOPS) begin
                            r_nxt.cur.hops = RX_DATA;
                        end else if (off == `HRFD_OFF_TXOPT) begin
                            r_nxt.cur.opts = RX_DATA;
                        end else if (off >= `HRFD_OFF_TPAY) begin
                            r_nxt.pay_valid = 1'b1;
                            r_nxt.pay_data = RX_DATA;
                        end
                    end
                end
                default: begin
                    r_nxt.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            r_r <= '0;
            r_r.rate <= `HRFD_RST_RATE;
            r_r.hop_lim <= `HRFD_RST_HOPS;
            r_r.en <= `HRFD_RST_EN;
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign PRDATA = r_r.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign FRM_VALID = r_r.frm_valid;
    assign FRM_ERR = r_r.frm_err;
    assign FRM = r_r.out;
    assign PAY_VALID = r_r.pay_valid;
    assign PAY_DATA = r_r.pay_data;
    assign PAR_SET = r_r.par_set;
    assign PAR_QUERY = r_r.par_query;
    assign PAR_CODE = r_r.par_code;
    assign PAR_VAL = r_r.par_val;
    assign SERIAL_RATE = r_r.rate;
    assign HOP_LIMIT = r_r.hop_lim;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    AST_NO_START: assert property (r_r.en && r_r.st == ST_IDLE && RX_VALID && RX_DATA != `HRFD_START
        |=> r_r.st == ST_IDLE) else $error("left idle without start byte");
    AST_BAD_SUM: assert property (r_r.en && r_r.st == ST_BODY && RX_VALID && r_r.idx == r_r.len
        && sum_nxt != `HRFD_CSUM_OK |=> FRM_ERR && !FRM_VALID) else $error("bad checksum accepted");
    AST_RESP: assert property (FRM_VALID |-> FRM.resp_due == (FRM.fid != 8'h00))
        else $error("response flag wrong");
    AST_BCAST: assert property (FRM_VALID && FRM.ftype == `HRFD_T_LEGACY
        |-> FRM.bcast == (FRM.dest == `HRFD_BCAST)) else $error("broadcast flag wrong");
    AST_SET_SRC: assert property (PAR_SET |-> FRM_VALID && FRM.ftype != `HRFD_T_LEGACY
        && FRM.ftype != `HRFD_T_TX) else $error("parameter set without command");
    AST_RATE: assert property (PAR_SET && PAR_CODE == `HRFD_CODE_RATE |-> SERIAL_RATE == PAR_VAL)
        else $error("rate not applied");
    AST_QUEUE: assert property (FRM_VALID && FRM.ftype == `HRFD_T_ATQ && r_r.stg_pend
        && !$past(PSEL) |-> $stable(SERIAL_RATE)) else $error("queued value applied");
    AST_TXOPT: assert property (FRM_VALID && FRM.ftype == `HRFD_T_TX
        |-> FRM.opts[5:4] == 2'b00 && FRM.opts[7:6] != 2'b00) else $error("bad options accepted");
    AST_TYPE: assert property (FRM_VALID |-> FRM.ftype inside {`HRFD_T_LEGACY, `HRFD_T_ATNOW,
        `HRFD_T_ATQ, `HRFD_T_TX}) else $error("unsupported type accepted");
    AST_PAY: assert property (PAY_VALID |-> ##[1:300] (FRM_VALID || FRM_ERR))
        else $error("payload without frame end");
endmodule // hrfd_decoder
`default_nettype wire

// ===== verif/hrfd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hrfd_host_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // A released line shows the inverse of the last byte, so stale data never passes for fresh
    // Called just after a rising edge; the byte is taken at the next one, a gap idles one more edge
    task automatic put(input logic [7:0] b, input bit gap);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge clk);
        if (gap) begin
            rx_valid <= 1'b0;
            rx_data <= ~b;
            @(posedge clk);
        end
    endtask
    task automatic send(input logic [7:0] body[$], input logic [7:0] flip, input bit gap);
        logic [7:0] sum;
        logic [15:0] len;
        sum = 8'h00;
        len = 16'(body.size());
        put(8'h7e, 1'b1);
        put(len[15:8], gap);
        put(len[7:0], gap);
        foreach (body[i]) begin
            sum = sum + body[i];
            put(body[i], gap);
        end
        put((8'hff - sum) ^ flip, 1'b1);
    endtask
endmodule // hrfd_host_model
`default_nettype wire

// ===== verif/hrfd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrfd_params.svh"
module hrfd_decoder_tb;
    import hrfd_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, serial_rate, par_val;
    logic pready, pslverr, rx_valid, frm_valid, frm_err, pay_valid, par_set, par_query;
    logic [7:0] rx_data, pay_data, hop_limit;
    logic [15:0] par_code;
    hrfd_frame_t frm, last_frm;
    logic [7:0] pay_q[$];
    logic [31:0] seed = 32'h9640768e;
    int n_errors = 0, checks_done = 0, n_ok = 0, n_bad = 0, n_qry = 0, n_good = 0, cyc = 0;
    int n_set = 0, n_rej = 0;

    always #12.5 clock = ~clock;

    hrfd_host_model hrfd_host_model_inst (.clk(clock), .rx_valid(rx_valid), .rx_data(rx_data));
    hrfd_decoder hrfd_decoder_inst (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_DATA(rx_data), .FRM_VALID(frm_valid),
        .FRM_ERR(frm_err), .FRM(frm), .PAY_VALID(pay_valid), .PAY_DATA(pay_data), .PAR_SET(par_set),
        .PAR_QUERY(par_query), .PAR_CODE(par_code), .PAR_VAL(par_val), .SERIAL_RATE(serial_rate),
        .HOP_LIMIT(hop_limit));

    always @(posedge clock) begin
        cyc++;
        if (frm_valid === 1'b1) begin
            n_ok++;
            last_frm = frm;
        end
        if (frm_err === 1'b1) n_bad++;
        if (pay_valid === 1'b1) pay_q.push_back(pay_data);
        if (par_query === 1'b1) n_qry++;
        if (par_set === 1'b1) n_set++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_hops(input logic [7:0] given, input logic [7:0] lim);
        return (given == 8'h00) ? lim : given;
    endfunction
    function automatic bit exp_opt_ok(input logic [7:0] op);
        return op[5:4] == 2'b00 && op[7:6] != 2'b00;
    endfunction

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the bench timeout ends a wait that never sees ready
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Exp: 1 accepted, 0 rejected, 2 silently dropped
    task automatic frame(input logic [7:0] body[$], input logic [7:0] flip, input int exp);
        int ok0, bad0, k;
        ok0 = n_ok;
        bad0 = n_bad;
        pay_q = {};
        hrfd_host_model_inst.put(8'h55, 1'b1);
        hrfd_host_model_inst.send(body, flip, rnd() > 8'h80);
        k = 0;
        while (n_ok == ok0 && n_bad == bad0 && k < 8) begin
            k++;
            @(posedge clock);
        end
        if (exp == 1) n_good++;
        if (exp == 0) n_rej++;
        chk("frame_ok", n_ok - ok0, exp == 1);
        chk("frame_err", n_bad - bad0, exp == 0);
    endtask
    task automatic chk_pay(input logic [7:0] exp[$]);
        chk("pay_len", pay_q.size(), exp.size());
        foreach (exp[i]) chk("pay", pay_q[i], exp[i]);
    endtask

    initial begin
        logic [7:0] b[$], p[$], fid, op, hp, v, lim;
        logic [63:0] dst;
        logic [31:0] rd;
        logic er;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, `HRFD_A_CTRL, 0, rd, er);
        chk("ctrl_rst", rd, 1);
        apb(1'b0, `HRFD_A_RATE, 0, rd, er);
        chk("rate_rst", rd, `HRFD_RST_RATE);
        apb(1'b0, 8'h40, 0, rd, er);
        chk("unmapped_err", er, 1);
        lim = 8'h09;
        apb(1'b1, `HRFD_A_HOPS, 32'(lim), rd, er);
        apb(1'b0, `HRFD_A_HOPS, 0, rd, er);
        chk("hop_wr", hop_limit, lim);
        chk("hop_rd", rd, 32'(lim));
        for (int i = 0; i < 2; i++) begin
            dst = i ? `HRFD_BCAST : {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            fid = i ? 8'h00 : (rnd() | 8'h01);
            p = {rnd(), rnd(), rnd()};
            b = {8'h00, fid};
            for (int j = 7; j >= 0; j--) b.push_back(dst[j*8+:8]);
            b.push_back(8'(i));
            frame({b, p}, 8'h00, 1);
            chk("l_type", last_frm.ftype, 8'h00);
            chk("l_dest", last_frm.dest, dst);
            chk("l_bcast", last_frm.bcast, i);
            chk("l_resp", last_frm.resp_due, !i);
            chk("l_fid", last_frm.fid, fid);
            chk("l_opts", last_frm.opts, 8'(i));
            chk_pay(p);
            frame({b[0:9], 8'h02, p}, 8'h00, 0);
            frame(b[0:9], 8'h00, 0);
            frame({b, p}, 8'h01 << i, 0);
        end
        frame({8'h11, 8'h01, 8'h00, 8'h00}, 8'h00, 0);
        frame({8'h08, 8'h52, 8'h4e, 8'h48}, 8'h00, 1);
        chk("qry", n_qry, 1);
        chk("qry_code", par_code, `HRFD_CODE_HOPS);
        frame({8'h09, 8'h01, 8'h42, 8'h44, 8'h07}, 8'h00, 1);
        chk("rate_held", serial_rate, `HRFD_RST_RATE);
        apb(1'b0, `HRFD_A_STAT, 0, rd, er);
        chk("staged", rd[0], 1);
        chk("stat_type", rd[15:8], 8'h09);
        frame({8'h09, 8'h00, 8'h41, 8'h43}, 8'h00, 1);
        chk("rate_apply", serial_rate, 32'h7);
        for (int w = 1; w <= 4; w *= 2) begin
            v = (rnd() & 8'h7f) + 8'h01;
            b = {8'h08, 8'h01, 8'h42, 8'h44};
            repeat (w - 1) b.push_back(8'h00);
            frame({b, v}, 8'h00, 1);
            chk("rate_now", serial_rate, 32'(v));
            chk("par_val", par_val, 32'(v));
        end
        frame({8'h08, 8'h01, 8'h42, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h00, 0);
        lim = 8'h05;
        frame({8'h09, 8'h01, 8'h4e, 8'h48, lim}, 8'h00, 1);
        chk("hop_held", hop_limit, 8'h09);
        frame({8'h08, 8'h01, 8'h42, 8'h44, 8'h00, 8'h02}, 8'h00, 1);
        chk("hop_apply", hop_limit, lim);
        frame({8'h09, 8'h01, 8'h4e, 8'h48}, 8'h00, 1);
        chk("qry2", n_qry, 2);
        for (int i = 0; i < 4; i++) begin
            dst = i ? {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()} : `HRFD_BCAST;
            hp = (i == 0) ? 8'h00 : rnd();
            op = (i < 2) ? {i ? 2'b11 : 2'b01, 2'b00, 4'(rnd())} : ((i == 2) ? 8'h50 : 8'h03);
            p = {rnd()};
            repeat (rnd() & 8'h03) p.push_back(rnd());
            b = {8'h10, 8'h01};
            for (int j = 7; j >= 0; j--) b.push_back(dst[j*8+:8]);
            b.push_back(8'hff);
            b.push_back(8'hfe);
            frame({b, hp, op, p}, 8'h00, exp_opt_ok(op));
            if (exp_opt_ok(op)) begin
                chk("t_dest", last_frm.dest, dst);
                chk("t_bcast", last_frm.bcast, i == 0);
                chk("t_hops", last_frm.hops, exp_hops(hp, lim));
                chk("t_opts", last_frm.opts, op);
                chk_pay(p);
            end
        end
        frame(b[0:11], 8'h00, 0);
        apb(1'b1, `HRFD_A_CTRL, 0, rd, er);
        frame({8'h08, 8'h01, 8'h42, 8'h44}, 8'h00, 2);
        apb(1'b1, `HRFD_A_CTRL, 1, rd, er);
        apb(1'b0, `HRFD_A_GOOD, 0, rd, er);
        chk("good_cnt", rd, 32'(n_good));
        apb(1'b0, `HRFD_A_BAD, 0, rd, er);
        chk("bad_cnt", rd, 32'(n_rej));
        // One staged apply, three immediate sets, one staged-plus-own apply in a single cycle
        chk("set_cnt", n_set, 5);
        tally_and_finish();
    end
endmodule // hrfd_decoder_tb
`default_nettype wire
